// File: resq_edge_delay.v
// Purpose: Delays the rising and falling edges of one rail's enable request.
// Assumes: ms_tick pulses once per millisecond; codes are stable while used.
// Notes:   A new edge restarts the wait; a reversal cancels a pending edge.
`timescale 1ns/10ps
`include "resq_map.vh"

module resq_edge_delay (
	input  wire       clk,
	input  wire       reset_n,
	input  wire       ms_tick,
	input  wire       req,
	input  wire [2:0] on_code,
	input  wire [2:0] off_code,
	output wire       busy,
	output reg        rail_en_q
);

	reg  [6:0] left_q;
	reg  [6:0] left_d;
	reg        rail_en_d;
	reg        req_q;

	// Code to milliseconds, shared by both edges
	function [6:0] resq_code_ms;
		input [2:0] code;
		begin
			case (code)
				3'h1:    resq_code_ms = 7'd`RESQ_DLY_MS_1;
				3'h2:    resq_code_ms = 7'd`RESQ_DLY_MS_2;
				3'h3:    resq_code_ms = 7'd`RESQ_DLY_MS_3;
				3'h4:    resq_code_ms = 7'd`RESQ_DLY_MS_4;
				3'h5:    resq_code_ms = 7'd`RESQ_DLY_MS_5;
				3'h6:    resq_code_ms = 7'd`RESQ_DLY_MS_6;
				3'h7:    resq_code_ms = 7'd`RESQ_DLY_MS_7;
				default: resq_code_ms = 7'd0;
			endcase
		end
	endfunction

	assign busy = (left_q != 7'd0);

	// Edge detection and countdown
	always @* begin
		left_d    = left_q;
		rail_en_d = rail_en_q;
		if (req != req_q) begin
			if (req == rail_en_q) begin
				left_d = 7'd0; // Reversal before expiry cancels
			end else if (req && resq_code_ms(on_code) == 7'd0) begin
				rail_en_d = 1'b1;
			end else if (!req && resq_code_ms(off_code) == 7'd0) begin
				rail_en_d = 1'b0;
			end else begin
				left_d = req ? resq_code_ms(on_code) : resq_code_ms(off_code);
			end
		end else if (left_q != 7'd0 && ms_tick) begin
			left_d = left_q - 7'd1;
			if (left_q == 7'd1) begin
				rail_en_d = req_q;
			end
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			left_q    <= 7'd0;
			rail_en_q <= 1'b0;
			req_q     <= 1'b0;
		end else begin
			left_q    <= left_d;
			rail_en_q <= rail_en_d;
			req_q     <= req;
		end
	end

endmodule

// File: resq_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the two-rail enable sequencing slice.
// Assumes: 40 MHz core clock, 8-bit configuration registers.
// Notes:   Definitions only.
`ifndef RESQ_MAP_VH
`define RESQ_MAP_VH

// Register offsets
`define RESQ_OFS_CONV_F_CFG_B     8'h17
`define RESQ_OFS_CONV_F_DELAYS    8'h18
`define RESQ_OFS_LSW_A_PG_MASKS   8'h19
`define RESQ_OFS_LSW_A_CFG_B      8'h1a

// Reset values
`define RESQ_RST_CONV_F_CFG_B     8'hc0
`define RESQ_RST_CONV_F_DELAYS    8'h00
`define RESQ_RST_LSW_A_PG_MASKS   8'h00
`define RESQ_RST_LSW_A_CFG_B      8'h00

// Field positions
`define RESQ_BIT_MASK_SWB_FIRST   0
`define RESQ_BIT_MASK_SWB2_LIN1   1
`define RESQ_SRC_LSB              2
`define RESQ_SRC_MSB              4
`define RESQ_BIT_VOLTAGE_STEP     5
`define RESQ_PGSEL_LSB            5
`define RESQ_PGSEL_MSB            6
`define RESQ_ON_DLY_LSB           0
`define RESQ_ON_DLY_MSB           2
`define RESQ_OFF_DLY_LSB          3
`define RESQ_OFF_DLY_MSB          5
`define RESQ_BIT_MASK_CONV_F      5
`define RESQ_BIT_MASK_CONV_E      4
`define RESQ_MASK_LOW_MSB         3
`define RESQ_MASK_LOW_LSB         0
`define RESQ_BIT_MASK_LIN2        6
`define RESQ_BIT_MASK_LIN3        7

// Enable source codes
`define RESQ_SRC_IN1              3'h0
`define RESQ_SRC_IN2              3'h1
`define RESQ_SRC_IN5              3'h2
`define RESQ_SRC_IN4              3'h3
`define RESQ_SRC_IN3              3'h4
`define RESQ_SRC_IN3_AND_IN4      3'h5
`define RESQ_SRC_IN6              3'h6
`define RESQ_SRC_ALWAYS           3'h7

// Timing: one millisecond tick at the core clock
`define RESQ_CLK_HZ               40000000
`define RESQ_TICK_MS              1
`define RESQ_TICK_CYCLES          (`RESQ_CLK_HZ / 1000 * `RESQ_TICK_MS)
`define RESQ_DLY_MS_1             2
`define RESQ_DLY_MS_2             4
`define RESQ_DLY_MS_3             8
`define RESQ_DLY_MS_4             16
`define RESQ_DLY_MS_5             24
`define RESQ_DLY_MS_6             32
`define RESQ_DLY_MS_7             64

`endif

// File: resq_props.sv
// Purpose: Assertions on the ports of the rail enable slice.
// Assumes: The register mirror starts at the reset values.
// Notes:   Bound into resq_rail_seq below.
`timescale 1ns/10ps
module resq_props (
	input wire       clk,
	input wire       reset_n,
	input wire [7:0] reg_addr,
	input wire       reg_wr,
	input wire [7:0] reg_wdata,
	input wire       control_input_one,
	input wire       control_input_two,
	input wire       control_input_three,
	input wire       control_input_four,
	input wire       control_input_five,
	input wire       control_input_six,
	input wire [5:0] power_good_conv,
	input wire       power_good_swb_first,
	input wire       power_good_swb2_lin1,
	input wire       power_good_linear_reg_two,
	input wire       power_good_linear_reg_three,
	input wire       conv_f_enable,
	input wire       conv_f_voltage_step,
	input wire       lsw_a_enable,
	input wire       conv_f_pending
);
	reg  [31:0] m_q;
	reg  [31:0] cnt_q;
	reg         pq_q;
	wire [5:0]  pin = {control_input_six, control_input_five, control_input_four,
		control_input_three, control_input_two, control_input_one};
	wire [7:0]  lpg = {power_good_linear_reg_three, power_good_linear_reg_two, power_good_conv};
	wire [31:0] ins = {pin, lpg, power_good_swb2_lin1, power_good_swb_first, m_q[31:16]};
	// Selected control source, a constant one for code 111
	function sel(input [2:0] c, input [5:0] p);
		sel = (c == 3'h7) | (c == 3'h5 ? p[2] & p[3] : p[(24'h142708 >> (c * 3)) & 24'h7]);
	endfunction
	wire req_c = sel(m_q[4:2], pin) & (m_q[1] | power_good_swb2_lin1) & (m_q[0] | power_good_swb_first);
	wire req_l = sel(m_q[28:26], pin) & (&(m_q[23:16] | lpg));
	// Mirror of registers 17h to 1ah and length of the pending run
	always @(posedge clk) begin
		if (!reset_n) begin
			m_q   <= 32'h000000c0;
			cnt_q <= 32'h0;
			pq_q  <= 1'b0;
		end else begin
			if (reg_wr && reg_addr >= 8'h17 && reg_addr <= 8'h1a)
				m_q[(reg_addr - 8'h17) * 8 +: 8] <= reg_wdata;
			pq_q <= conv_f_pending;
			if (conv_f_pending)
				cnt_q <= pq_q ? cnt_q + 32'h1 : 32'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_quiet(r);
		(r && $stable(ins) && $stable(m_q[7:0]) && m_q[15:8] == 8'h00) [*5];
	endsequence
	property p_step; conv_f_voltage_step == m_q[5]; endproperty
	a_step: assert property (p_step) else $error("step output differs from register");
	property p_conv_on; s_quiet(req_c) |-> conv_f_enable; endproperty
	a_conv_on: assert property (p_conv_on) else $error("converter not enabled");
	property p_conv_off; s_quiet(!req_c) |-> !conv_f_enable; endproperty
	a_conv_off: assert property (p_conv_off) else $error("converter enabled");
	property p_src_one; (m_q[4:0] == 5'h1f && m_q[15:8] == 8'h00) [*5] |-> conv_f_enable; endproperty
	a_src_one: assert property (p_src_one) else $error("constant source failed");
	property p_lsw_on; s_quiet(req_l) |-> lsw_a_enable; endproperty
	a_lsw_on: assert property (p_lsw_on) else $error("load switch not enabled");
	property p_lsw_off; s_quiet(!req_l) |-> !lsw_a_enable; endproperty
	a_lsw_off: assert property (p_lsw_off) else $error("load switch enabled");
	property p_on_dly;
		$rose(conv_f_enable) && m_q[10:8] == 3'h1 |-> cnt_q >= 32'h9c36 && cnt_q <= 32'h1388a;
	endproperty
	a_on_dly: assert property (p_on_dly) else $error("rising delay out of range");
	property p_hold; conv_f_pending && $past(conv_f_pending) |-> $stable(conv_f_enable); endproperty
	a_hold: assert property (p_hold) else $error("enable moved while pending");
endmodule
bind resq_rail_seq resq_props resq_props_i (.*);

// File: resq_rail_seq.v
// Purpose: Enable sequencing for converter rail F and load-switch rail A.
// Assumes: Control inputs and power-good levels arrive asynchronously.
// Notes:   Registers are reached through a simple byte register port.
`timescale 1ns/10ps
`include "resq_map.vh"

// Summary of operation
// - Source codes 000, 001, 010, 011 pick control inputs one, two, five and four.
// - Codes 100, 101, 110, 111 pick input three, three and four, input six, or a constant one.
// - Converter mask bit one set to 0 makes switch-B2/linear-one power good gate the enable.
// - Converter mask bit zero set to 0 makes switch-B first power good gate the enable.
// - The step bit selects 10 mV when 0 and 25 mV when 1 and drives conv_f_voltage_step directly as written.
// - A rising enable waits the on-delay code (0 to 64 ms) before the rail turns on.
// - A falling enable waits the off-delay code, same mapping, before the rail turns off.
// - Load-switch mask bit 7 excludes linear three power good when 1.
// - Load-switch mask bit 6 excludes linear two power good when 1.
// - Load-switch mask bit 4 excludes converter five power good when 1.
// - Load-switch mask bits 3 to 0 exclude converters four to one power good when 1.
// - The load-switch enable source uses the same code table as the converter.
module resq_rail_seq (
	input  wire       clk,
	input  wire       reset_n,
	input  wire [7:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	input  wire       control_input_one,
	input  wire       control_input_two,
	input  wire       control_input_three,
	input  wire       control_input_four,
	input  wire       control_input_five,
	input  wire       control_input_six,
	input  wire [5:0] power_good_conv,
	input  wire       power_good_swb_first,
	input  wire       power_good_swb2_lin1,
	input  wire       power_good_linear_reg_two,
	input  wire       power_good_linear_reg_three,
	output wire       conv_f_enable,
	output wire       conv_f_voltage_step,
	output wire       lsw_a_enable,
	output wire [1:0] lsw_a_pg_threshold,
	output wire       conv_f_pending,
	output wire       lsw_a_pending
);

	// Full-width count first, then cut to the counter width on purpose
	localparam [31:0] TICK_FULL = `RESQ_TICK_CYCLES - 1;
	localparam [16:0] TICK_LAST = TICK_FULL[16:0];

	reg  [7:0]  conv_f_cfg_b_q;
	reg  [7:0]  conv_f_delays_q;
	reg  [7:0]  lsw_a_pg_masks_q;
	reg  [7:0]  lsw_a_cfg_b_q;
	wire [15:0] raw_in;
	wire [15:0] sync_w;
	wire [3:0]  addr_hit;
	reg  [16:0] tick_cnt_q;
	reg         ms_tick_q;
	wire [5:0]  ctl_s;
	wire [5:0]  pg_conv_s;
	wire        pg_switch_b_first_s;
	wire        pg_swb2_s;
	wire        pg_lin2_s;
	wire        pg_lin3_s;
	wire        conv_f_req;
	wire        lsw_a_req;

	// Enable source multiplexer shared by both rails
	function resq_src_sel;
		input [2:0] code;
		input [5:0] ctl;
		begin
			case (code)
				`RESQ_SRC_IN1:         resq_src_sel = ctl[0];
				`RESQ_SRC_IN2:         resq_src_sel = ctl[1];
				`RESQ_SRC_IN5:         resq_src_sel = ctl[4];
				`RESQ_SRC_IN4:         resq_src_sel = ctl[3];
				`RESQ_SRC_IN3:         resq_src_sel = ctl[2];
				`RESQ_SRC_IN3_AND_IN4: resq_src_sel = ctl[2] & ctl[3];
				`RESQ_SRC_IN6:         resq_src_sel = ctl[5];
				`RESQ_SRC_ALWAYS:      resq_src_sel = 1'b1;
				default:               resq_src_sel = 1'b0;
			endcase
		end
	endfunction

	// Offset decode, shared by the write and the read path
	function [3:0] resq_addr_dec;
		input [7:0] addr;
		begin
			case (addr)
				`RESQ_OFS_CONV_F_CFG_B:   resq_addr_dec = 4'h1;
				`RESQ_OFS_CONV_F_DELAYS:  resq_addr_dec = 4'h2;
				`RESQ_OFS_LSW_A_PG_MASKS: resq_addr_dec = 4'h4;
				`RESQ_OFS_LSW_A_CFG_B:    resq_addr_dec = 4'h8;
				default:                  resq_addr_dec = 4'h0;
			endcase
		end
	endfunction

	// Asynchronous pins and power-good levels gathered into one vector
	assign raw_in = {power_good_linear_reg_three,
	                 power_good_linear_reg_two,
	                 power_good_swb2_lin1,
	                 power_good_swb_first,
	                 power_good_conv,
	                 control_input_six,
	                 control_input_five,
	                 control_input_four,
	                 control_input_three,
	                 control_input_two,
	                 control_input_one};

	// Two-stage synchronisers; only the second stage feeds any logic
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_sync
			reg meta_q;
			reg sync_q;
			always @(posedge clk) begin
				if (!reset_n) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= raw_in[gi];
					sync_q <= meta_q;
				end
			end
			assign sync_w[gi] = sync_q;
		end
	endgenerate

	assign ctl_s     = sync_w[5:0];
	assign pg_conv_s = sync_w[11:6];
	assign pg_switch_b_first_s = sync_w[12];
	assign pg_swb2_s = sync_w[13];
	assign pg_lin2_s = sync_w[14];
	assign pg_lin3_s = sync_w[15];

	// One-hot select of the addressed register
	assign addr_hit = resq_addr_dec(reg_addr);

	// Register writes, one decoded strobe per register
	always @(posedge clk) begin
		if (!reset_n) begin
			conv_f_cfg_b_q   <= `RESQ_RST_CONV_F_CFG_B;
			conv_f_delays_q  <= `RESQ_RST_CONV_F_DELAYS;
			lsw_a_pg_masks_q <= `RESQ_RST_LSW_A_PG_MASKS;
			lsw_a_cfg_b_q    <= `RESQ_RST_LSW_A_CFG_B;
		end else if (reg_wr) begin
			if (addr_hit[0]) begin
				conv_f_cfg_b_q <= reg_wdata;
			end
			if (addr_hit[1]) begin
				conv_f_delays_q <= reg_wdata;
			end
			if (addr_hit[2]) begin
				lsw_a_pg_masks_q <= reg_wdata;
			end
			if (addr_hit[3]) begin
				lsw_a_cfg_b_q <= reg_wdata;
			end
		end
	end

	// Registered read data; unmapped offsets read zero
	always @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			case (addr_hit)
				4'h1:    reg_rdata <= conv_f_cfg_b_q;
				4'h2:    reg_rdata <= conv_f_delays_q;
				4'h4:    reg_rdata <= lsw_a_pg_masks_q;
				4'h8:    reg_rdata <= lsw_a_cfg_b_q;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Millisecond timebase for the edge delays
	always @(posedge clk) begin
		if (!reset_n) begin
			tick_cnt_q <= 17'd0;
			ms_tick_q  <= 1'b0;
		end else if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= 17'd0;
			ms_tick_q  <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 17'd1;
			ms_tick_q  <= 1'b0;
		end
	end

	// Converter rail F request: source gated by unmasked power good
	assign conv_f_req = resq_src_sel(conv_f_cfg_b_q[`RESQ_SRC_MSB:`RESQ_SRC_LSB], ctl_s)
	                  & (pg_swb2_s | conv_f_cfg_b_q[`RESQ_BIT_MASK_SWB2_LIN1])
	                  & (pg_switch_b_first_s | conv_f_cfg_b_q[`RESQ_BIT_MASK_SWB_FIRST]);

	// Load-switch rail A request: same source table, eight power-good masks
	assign lsw_a_req = resq_src_sel(lsw_a_cfg_b_q[`RESQ_SRC_MSB:`RESQ_SRC_LSB], ctl_s)
	                 & (pg_lin3_s | lsw_a_pg_masks_q[`RESQ_BIT_MASK_LIN3])
	                 & (pg_lin2_s | lsw_a_pg_masks_q[`RESQ_BIT_MASK_LIN2])
	                 & (pg_conv_s[5] | lsw_a_pg_masks_q[`RESQ_BIT_MASK_CONV_F])
	                 & (pg_conv_s[4] | lsw_a_pg_masks_q[`RESQ_BIT_MASK_CONV_E])
	                 & (&(pg_conv_s[3:0]
	                      | lsw_a_pg_masks_q[`RESQ_MASK_LOW_MSB:`RESQ_MASK_LOW_LSB]));

	// Step size is a plain configuration output to the regulator
	assign conv_f_voltage_step = conv_f_cfg_b_q[`RESQ_BIT_VOLTAGE_STEP];
	assign lsw_a_pg_threshold  = lsw_a_cfg_b_q[`RESQ_PGSEL_MSB:`RESQ_PGSEL_LSB];

	// Converter rail F edge delays
	resq_edge_delay u_conv_f_dly (
		.clk       (clk),
		.reset_n   (reset_n),
		.ms_tick   (ms_tick_q),
		.req       (conv_f_req),
		.on_code   (conv_f_delays_q[`RESQ_ON_DLY_MSB:`RESQ_ON_DLY_LSB]),
		.off_code  (conv_f_delays_q[`RESQ_OFF_DLY_MSB:`RESQ_OFF_DLY_LSB]),
		.busy      (conv_f_pending),
		.rail_en_q (conv_f_enable)
	);

	// Load-switch rail A: no delay register in this slice, so zero delay
	resq_edge_delay u_lsw_a_dly (
		.clk       (clk),
		.reset_n   (reset_n),
		.ms_tick   (ms_tick_q),
		.req       (lsw_a_req),
		.on_code   (3'h0),
		.off_code  (3'h0),
		.busy      (lsw_a_pending),
		.rail_en_q (lsw_a_enable)
	);

endmodule

// File: resq_rail_seq_bench.sv
// Purpose: Self-checking bench for the rail enable slice.
// Assumes: Stimulus on the falling edge of a 25 ns clock.
// Notes:   Expected results queue up for a separate compare process.
`timescale 1ns/10ps
module resq_rail_seq_bench;
	reg        clk, reset_n, reg_wr;
	reg  [7:0] reg_addr, reg_wdata, c17, c19, c1a, o;
	reg  [5:0] want;
	reg  [9:0] pg;
	wire [5:0] pin;
	wire [7:0] reg_rdata;
	wire [1:0] thr;
	wire       cen, step, len, pend, lpend;
	integer    mismatches, cmp_count, seed, i, k;
	reg  [7:0] kq[$];
	reg  [7:0] eq[$];
	resq_sys_ctl resq_sys_ctl_i (.want(want), .pins(pin));
	resq_rail_seq resq_rail_seq_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.control_input_one(pin[0]), .control_input_two(pin[1]), .control_input_three(pin[2]),
		.control_input_four(pin[3]), .control_input_five(pin[4]), .control_input_six(pin[5]),
		.power_good_conv(pg[5:0]), .power_good_linear_reg_two(pg[6]),
		.power_good_linear_reg_three(pg[7]), .power_good_swb_first(pg[8]),
		.power_good_swb2_lin1(pg[9]), .conv_f_enable(cen), .conv_f_voltage_step(step),
		.lsw_a_enable(len), .lsw_a_pg_threshold(thr), .conv_f_pending(pend),
		.lsw_a_pending(lpend));
	function sel(input [2:0] c, input [5:0] p);
		sel = (c == 3'h7) | (c == 3'h5 ? p[2] & p[3] : p[(24'h142708 >> (c * 3)) & 24'h7]);
	endfunction
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task note(input [7:0] kind, input [7:0] e);
		begin
			kq.push_back(kind);
			eq.push_back(e);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			reg_addr = a;
			reg_wdata = d;
			reg_wr = 1'b1;
			cyc(1);
			reg_wr = 1'b0;
			cyc(1);
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			reg_addr = a;
			cyc(2);
			note(0, e);
		end
	endtask
	task wrap_up;
		begin
			$display("compares %0d mismatches %0d", cmp_count, mismatches);
			if (mismatches == 0 && cmp_count > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Compare the oldest note with the settled outputs
	initial begin
		forever begin
			wait (kq.size() != 0);
			#1;
			k = kq.pop_front();
			o = k == 0 ? reg_rdata : k == 1 ? {7'h00, cen} : k == 2 ? {7'h00, len} :
				k == 3 ? {5'h00, step, thr} : {6'h00, lpend, pend};
			cmp_count = cmp_count + 1;
			if (o !== eq[0]) begin
				mismatches = mismatches + 1;
				$display("FAIL %0t kind %0d got %h expected %h", $time, k, o, eq[0]);
			end
			o = eq.pop_front();
		end
	end
	// Watchdog against a hang
	initial begin
		repeat (95000) @(negedge clk);
		mismatches = mismatches + 1;
		wrap_up;
	end
	// Main sequence
	initial begin
		{reset_n, reg_wr, reg_addr, reg_wdata, want} = 0;
		pg = 10'h3ff;
		mismatches = 0;
		cmp_count = 0;
		seed = 32'hfcc9b834;
		cyc(8);
		reset_n = 1'b1;
		rd(8'h17, 8'hc0);
		rd(8'h18, 8'h00);
		rd(8'h19, 8'h00);
		rd(8'h1a, 8'h00);
		rd(8'h33, 8'h00);
		$display("test reset_values done");
		// Every source code on both rails with random masks and power good
		for (i = 0; i < 40; i = i + 1) begin
			c17 = $random(seed);
			c17[4:2] = i[2:0];
			c17[5] = 1'b0;
			if (i[3])
				c17[1:0] = 2'b11;
			c19 = $random(seed) | $random(seed);
			c1a = $random(seed);
			c1a[4:2] = i[2:0] + 3'h3;
			wr(8'h17, c17);
			wr(8'h19, c19);
			wr(8'h1a, c1a);
			rd(8'h19, c19);
			want = $random(seed);
			pg = $random(seed) | $random(seed);
			cyc(7);
			note(1, {7'h00, sel(c17[4:2], want) & (c17[1] | pg[9]) & (c17[0] | pg[8])});
			note(2, {7'h00, sel(c1a[4:2], want) & (&(c19 | pg[7:0]))});
			note(3, {5'h00, c17[5], c1a[6:5]});
			note(4, 8'h00);
		end
		$display("test sources_and_masks done");
		// Rising edge held back by code 001, with the off code set to 000
		want = 6'h00;
		wr(8'h17, 8'hc3);
		wr(8'h18, 8'h01);
		cyc(7);
		note(1, 8'h00);
		want = 6'h01;
		cyc(1000);
		note(4, 8'h01);
		note(1, 8'h00);
		i = 0;
		while (cen !== 1'b1 && i < 81000) begin
			cyc(1);
			i = i + 1;
		end
		note(1, (i >= 38990 && i <= 79010) ? 8'h01 : 8'h02);
		// Falling edge held back by off code 001, then cancelled by a reversal
		wr(8'h18, 8'h08);
		want = 6'h00;
		cyc(1000);
		note(4, 8'h01);
		note(1, 8'h01);
		want = 6'h01;
		cyc(7);
		note(4, 8'h00);
		note(1, 8'h01);
		wr(8'h18, 8'h00);
		want = 6'h00;
		cyc(7);
		note(1, 8'h00);
		$display("test edge_delays done");
		cyc(2);
		wrap_up;
	end
endmodule

// File: resq_sys_ctl.sv
// Purpose: System controller model that drives the six enable pins.
// Assumes: The bench asks for new pin levels just after a falling edge.
// Notes:   Pins follow 2 ns later, well clear of the rising edge.
`timescale 1ns/10ps
module resq_sys_ctl (
	input  wire [5:0] want,
	output reg  [5:0] pins
);
	// Drive the requested pattern after a short output delay
	initial pins = 6'h00;
	always @(want) begin
		pins <= #2 want;
	end
endmodule
